// File: gpi_edge_det.sv
`timescale 1ns/10ps
`default_nettype none
module gpi_edge_det (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pin_async,
  input wire logic [1:0] mode,
  output logic level_q,
  output logic event_q
);
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic [2:0] fill_q;
  logic rise;
  logic fall;

  // Two-stage synchroniser; first stage read only by the second
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
      fill_q <= 3'h0;
    end else begin
      sync1_q <= pin_async;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      fill_q <= {fill_q[1:0], 1'b1};
    end
  end

  // No edge until the pipe holds real samples; an idle-high pin gives no false rise
  assign rise = fill_q[2] & sync2_q & ~prev_q;
  assign fall = fill_q[2] & ~sync2_q & prev_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      event_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      level_q <= sync2_q;
      unique case (mode)
        gpi_pkg::EDGE_NONE: event_q <= 1'b0;
        gpi_pkg::EDGE_RISE: event_q <= rise;
        gpi_pkg::EDGE_FALL: event_q <= fall;
        gpi_pkg::EDGE_BOTH: event_q <= rise | fall;
      endcase
    end
  end

  chk_reset_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(rst)
    |-> !event_q ##1 !event_q ##1 !event_q ##1 !event_q)
    else $error("edge reported before synchroniser filled");
endmodule : gpi_edge_det
`default_nettype wire

// File: gpi_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module gpi_pin_model #(
  parameter int PINS = 8
) (
  input wire logic sys_clk,
  input wire logic [PINS-1:0] ext_en,
  input wire logic [PINS-1:0] ext_val,
  input wire logic [PINS-1:0] pin_out,
  input wire logic [PINS-1:0] pin_oe,
  input wire logic [PINS-1:0] pull_up_en,
  input wire logic [PINS-1:0] pull_down_en,
  input wire logic port_irq,
  output logic [PINS-1:0] pin_in,
  output int n_irq
);
  // ----------------------------------------
  // Pin levels and interrupt request counter
  // ----------------------------------------
  logic [PINS-1:0] last_q = '0;
  int irq_cnt = 0;
  assign n_irq = irq_cnt;
  // Unpulled, undriven pins wander every cycle
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pull_up_en | (~pull_down_en & ~last_q)));
  always @(posedge sys_clk) begin
    last_q <= pin_in;
  end
  // Counts cycles with the request high
  always @(posedge sys_clk) begin
    if (port_irq === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
    end
  end
endmodule : gpi_pin_model
`default_nettype wire

// File: gpi_pkg.sv
package gpi_pkg;
  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_EDGE_MODE = 8'h00;
  localparam logic [7:0] REG_PORT_CFG = 8'h04;
  localparam logic [7:0] REG_OUT_DATA = 8'h08;
  localparam logic [7:0] REG_DRIVE_MODE = 8'h0C;
  localparam logic [7:0] REG_PIN_STATUS = 8'h10;
  localparam logic [7:0] REG_PIN_CLEAR = 8'h14;
  localparam logic [7:0] REG_PIN_IN = 8'h18;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] REG_IRQ_CLEAR = 8'h20;
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h24;
  // ---------------------------------------------------------------
  // Field positions of the port configuration register
  // ---------------------------------------------------------------
  localparam int CFG_THRESH_BIT = 0;
  localparam int CFG_SRC_EDGE_BIT = 1;
  localparam int CFG_VEC_LSB = 8;
  localparam int VEC_W = 8;
  // ---------------------------------------------------------------
  // Per-pin edge modes (two bits per pin)
  // ---------------------------------------------------------------
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Per-pin drive modes (two bits per pin)
  localparam logic [1:0] DRV_HIZ = 2'h0;
  localparam logic [1:0] DRV_STRONG = 2'h1;
  localparam logic [1:0] DRV_PULL_UP = 2'h2;
  localparam logic [1:0] DRV_PULL_DOWN = 2'h3;
  // Interrupt event bits
  localparam int EVT_PIN = 0;
  localparam int EVT_PORT_REQ = 1;
  localparam int EVT_W = 2;
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage : gpi_pkg

// File: gpi_port.sv
`timescale 1ns/10ps
`default_nettype none
module gpi_port #(
  parameter int PINS = 8,
  parameter logic [7:0] PORT_VECTOR = 8'h00
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe,
  output logic [PINS-1:0] pull_up_en,
  output logic [PINS-1:0] pull_down_en,
  output logic thresh_lvttl,
  output logic port_irq,
  output logic [7:0] port_irq_vector,
  output logic irq
);
  if (PINS < 1 || PINS > 16) begin : g_bad_pins
    $error("PINS must be 1 to 16");
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [31:0] edge_mode_q;
  logic [31:0] port_cfg_q;
  logic [PINS-1:0] out_data_q;
  logic [31:0] drive_mode_q;
  logic [PINS-1:0] pin_status_q;
  logic [PINS-1:0] pin_level;
  logic [PINS-1:0] pin_event;
  logic [gpi_pkg::EVT_W-1:0] irq_status_q;
  logic [gpi_pkg::EVT_W-1:0] irq_enable_q;
  logic port_or;
  logic port_or_prev_q;
  logic src_edge;
  logic port_req_d;
  logic ack_q;
  logic wr_stb;
  logic rd_stb;
  logic [PINS-1:0] pin_clear;
  logic [gpi_pkg::EVT_W-1:0] irq_clear;
  logic [gpi_pkg::EVT_W-1:0] irq_evt;

  // ---------------------------------------------------------------
  // Per-pin edge detectors
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pin
      gpi_edge_det u_det (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin_async(pin_in[gi]),
        .mode(edge_mode_q[2*gi+1:2*gi]),
        .level_q(pin_level[gi]),
        .event_q(pin_event[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, then acknowledge
  // ---------------------------------------------------------------
  assign wr_stb = avs_write & ack_q;
  // Read data captured in the wait cycle so it stands while waitrequest is low
  assign rd_stb = avs_read & ~ack_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
      avs_waitrequest <= ~((avs_read | avs_write) & ~ack_q);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      edge_mode_q <= gpi_pkg::RESET_VALUE;
      port_cfg_q <= gpi_pkg::RESET_VALUE;
      out_data_q <= '0;
      drive_mode_q <= gpi_pkg::RESET_VALUE;
      irq_enable_q <= '0;
    end else if (wr_stb) begin
      unique case (avs_address)
        gpi_pkg::REG_EDGE_MODE: edge_mode_q <= avs_writedata;
        gpi_pkg::REG_PORT_CFG: port_cfg_q <= avs_writedata;
        gpi_pkg::REG_OUT_DATA: out_data_q <= avs_writedata[PINS-1:0];
        gpi_pkg::REG_DRIVE_MODE: drive_mode_q <= avs_writedata;
        gpi_pkg::REG_IRQ_ENABLE: irq_enable_q <= avs_writedata[gpi_pkg::EVT_W-1:0];
        default: ;
      endcase
    end
  end

  assign pin_clear = (wr_stb && avs_address == gpi_pkg::REG_PIN_CLEAR) ?
                     avs_writedata[PINS-1:0] : '0;
  assign irq_clear = (wr_stb && avs_address == gpi_pkg::REG_IRQ_CLEAR) ?
                     avs_writedata[gpi_pkg::EVT_W-1:0] : '0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_readdata <= gpi_pkg::RESET_VALUE;
    end else if (rd_stb) begin
      unique case (avs_address)
        gpi_pkg::REG_EDGE_MODE: avs_readdata <= edge_mode_q;
        gpi_pkg::REG_PORT_CFG: avs_readdata <= port_cfg_q;
        gpi_pkg::REG_OUT_DATA: avs_readdata <= 32'(out_data_q);
        gpi_pkg::REG_DRIVE_MODE: avs_readdata <= drive_mode_q;
        gpi_pkg::REG_PIN_STATUS: avs_readdata <= 32'(pin_status_q);
        gpi_pkg::REG_PIN_IN: avs_readdata <= 32'(pin_level);
        gpi_pkg::REG_IRQ_STATUS: avs_readdata <= 32'(irq_status_q);
        gpi_pkg::REG_IRQ_ENABLE: avs_readdata <= 32'(irq_enable_q);
        default: avs_readdata <= gpi_pkg::UNMAPPED_READ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin status: set wins over clear
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_status_q <= '0;
    end else begin
      pin_status_q <= (pin_status_q & ~pin_clear) | pin_event;
    end
  end

  // ---------------------------------------------------------------
  // Port request and source mux
  // ---------------------------------------------------------------
  assign port_or = |pin_status_q;
  assign src_edge = port_cfg_q[gpi_pkg::CFG_SRC_EDGE_BIT];
  // Edge path pulses once per rise of the OR; stuck status blocks re-fire
  assign port_req_d = src_edge ? (port_or & ~port_or_prev_q) : port_or;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      port_or_prev_q <= 1'b0;
      port_irq <= 1'b0;
      port_irq_vector <= '0;
    end else begin
      port_or_prev_q <= port_or;
      port_irq <= port_req_d;
      port_irq_vector <= src_edge ? port_cfg_q[gpi_pkg::CFG_VEC_LSB +: gpi_pkg::VEC_W]
                                  : PORT_VECTOR;
    end
  end

  // ---------------------------------------------------------------
  // Pad controls
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      thresh_lvttl <= 1'b0;
    end else begin
      thresh_lvttl <= port_cfg_q[gpi_pkg::CFG_THRESH_BIT];
    end
  end

  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pad
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          pin_out[gi] <= 1'b0;
          pin_oe[gi] <= 1'b0;
          pull_up_en[gi] <= 1'b0;
          pull_down_en[gi] <= 1'b0;
        end else begin
          pin_out[gi] <= out_data_q[gi];
          pin_oe[gi] <= drive_mode_q[2*gi+1:2*gi] == gpi_pkg::DRV_STRONG;
          pull_up_en[gi] <= drive_mode_q[2*gi+1:2*gi] == gpi_pkg::DRV_PULL_UP
                            && out_data_q[gi];
          pull_down_en[gi] <= drive_mode_q[2*gi+1:2*gi] == gpi_pkg::DRV_PULL_DOWN
                              && !out_data_q[gi];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Interrupt status, enable and output
  // ---------------------------------------------------------------
  assign irq_evt = {port_req_d, |pin_event};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_status_q <= '0;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clear) | irq_evt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_status_q & ~irq_clear) | irq_evt) & irq_enable_q);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_or_level: assert property (@(posedge sys_clk) disable iff (rst)
    !src_edge && $stable(src_edge) |=> port_irq == $past(port_or))
    else $error("level request differs from OR of pin status");
  chk_level_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !src_edge && pin_status_q != '0 && pin_clear == '0 ##1 !src_edge |=> port_irq)
    else $error("level request dropped while status set");
  chk_edge_once: assert property (@(posedge sys_clk) disable iff (rst)
    src_edge && port_irq ##1 src_edge |-> !port_irq)
    else $error("edge path fired twice in a row");
  chk_edge_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    src_edge && port_or && !port_or_prev_q |=> port_irq)
    else $error("edge path missed rise of request");
  chk_vector_fix: assert property (@(posedge sys_clk) disable iff (rst)
    !src_edge |=> port_irq_vector == PORT_VECTOR)
    else $error("level path vector not fixed");
  chk_status_set: assert property (@(posedge sys_clk) disable iff (rst)
    pin_event != '0 |=> (pin_status_q & $past(pin_event)) == $past(pin_event))
    else $error("pin event did not set status");
  chk_pull_down: assert property (@(posedge sys_clk) disable iff (rst)
    pull_down_en[0] |-> !$past(out_data_q[0]))
    else $error("pull-down on with data high");
  chk_pull_up: assert property (@(posedge sys_clk) disable iff (rst)
    pull_up_en[0] |-> $past(out_data_q[0]))
    else $error("pull-up on with data low");
  chk_thresh_port: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 thresh_lvttl == $past(port_cfg_q[gpi_pkg::CFG_THRESH_BIT]))
    else $error("threshold not following port setting");
  chk_none_mode: assert property (@(posedge sys_clk) disable iff (rst)
    edge_mode_q[1:0] == gpi_pkg::EDGE_NONE ##1 edge_mode_q[1:0] == gpi_pkg::EDGE_NONE
    |-> !pin_event[0])
    else $error("pin event with edge mode none");

  // ---------------------------------------------------------------
  // Bus handshake checks
  // ---------------------------------------------------------------
  chk_one_wait: assert property (@(posedge sys_clk) disable iff (rst)
    (avs_read || avs_write) && !ack_q
    |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  chk_wait_single: assert property (@(posedge sys_clk) disable iff (rst)
    !avs_waitrequest
    |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_read_edge: assert property (@(posedge sys_clk) disable iff (rst)
    avs_read && !avs_waitrequest && avs_address == gpi_pkg::REG_EDGE_MODE
    |-> avs_readdata == edge_mode_q)
    else $error("edge mode read data not standing");
  chk_read_cfg: assert property (@(posedge sys_clk) disable iff (rst)
    avs_read && !avs_waitrequest && avs_address == gpi_pkg::REG_PORT_CFG
    |-> avs_readdata == port_cfg_q)
    else $error("port config read data not standing");
  chk_write_edge: assert property (@(posedge sys_clk) disable iff (rst)
    avs_write && !avs_waitrequest && avs_address == gpi_pkg::REG_EDGE_MODE
    |=> edge_mode_q == $past(avs_writedata))
    else $error("edge mode write lost");
  chk_write_cfg: assert property (@(posedge sys_clk) disable iff (rst)
    avs_write && !avs_waitrequest && avs_address == gpi_pkg::REG_PORT_CFG
    |=> port_cfg_q == $past(avs_writedata))
    else $error("port config write lost");

  // ---------------------------------------------------------------
  // Status and interrupt checks
  // ---------------------------------------------------------------
  chk_status_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    pin_status_q[0] && !pin_clear[0]
    |=> pin_status_q[0])
    else $error("pin status dropped without clear");
  chk_clear_drops: assert property (@(posedge sys_clk) disable iff (rst)
    pin_status_q != '0 && pin_clear == pin_status_q && pin_event == '0
    |=> ##1 !port_irq)
    else $error("request stays after status cleared");
  chk_edge_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    src_edge && pin_status_q == '0
    |=> !port_irq)
    else $error("edge path fired with no pin status");
  chk_edge_vector: assert property (@(posedge sys_clk) disable iff (rst)
    src_edge
    |=> port_irq_vector == $past(port_cfg_q[gpi_pkg::CFG_VEC_LSB +: gpi_pkg::VEC_W]))
    else $error("edge path vector not from port setting");
  chk_irq_pin_set: assert property (@(posedge sys_clk) disable iff (rst)
    pin_event != '0
    |=> irq_status_q[gpi_pkg::EVT_PIN])
    else $error("pin event did not set interrupt status");
  chk_irq_pin_clear: assert property (@(posedge sys_clk) disable iff (rst)
    irq_clear[gpi_pkg::EVT_PIN] && pin_event == '0
    |=> !irq_status_q[gpi_pkg::EVT_PIN])
    else $error("interrupt status not cleared");
  chk_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
    $stable(irq_enable_q)
    |-> irq == |(irq_status_q & irq_enable_q))
    else $error("interrupt output differs from enabled status");

  // ---------------------------------------------------------------
  // Pad checks
  // ---------------------------------------------------------------
  chk_strong_oe: assert property (@(posedge sys_clk) disable iff (rst)
    pin_oe[0]
    |-> $past(drive_mode_q[1:0]) == gpi_pkg::DRV_STRONG)
    else $error("output enable outside strong drive");
  chk_pull_excl: assert property (@(posedge sys_clk) disable iff (rst)
    pull_up_en[0]
    |-> !pull_down_en[0])
    else $error("pull-up and pull-down on together");

  // ---------------------------------------------------------------
  // Coverage
  // ---------------------------------------------------------------
  cov_level_irq: cover property (@(posedge sys_clk) !src_edge && port_irq);
  cov_edge_irq: cover property (@(posedge sys_clk) src_edge && port_irq);
  cov_clear_set: cover property (@(posedge sys_clk) (pin_clear & pin_event) != '0);
  cov_irq_out: cover property (@(posedge sys_clk) irq);
  cov_pull_down: cover property (@(posedge sys_clk) pull_down_en != '0);
endmodule : gpi_port
`default_nettype wire

// File: gpi_port_test.sv
`timescale 1ns/10ps
`default_nettype none
module gpi_port_test;
  typedef struct packed {logic [1:0] mode; logic v0; logic v1; logic hit;} gpi_row_t;
  localparam logic [7:0] VEC = 8'h2C;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, thresh_lvttl, port_irq, irq;
  logic [7:0] pin_in, pin_out, pin_oe, pull_up_en, pull_down_en, port_irq_vector;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] ext_en = 8'hFF;
  int n_irq, base;
  int n_fail = 0;
  int n_tests = 0;
  gpi_row_t rows [7] = '{
    '{gpi_pkg::EDGE_NONE, 1'b0, 1'b1, 1'b0}, '{gpi_pkg::EDGE_RISE, 1'b0, 1'b1, 1'b1},
    '{gpi_pkg::EDGE_RISE, 1'b1, 1'b0, 1'b0}, '{gpi_pkg::EDGE_FALL, 1'b1, 1'b0, 1'b1},
    '{gpi_pkg::EDGE_FALL, 1'b0, 1'b1, 1'b0}, '{gpi_pkg::EDGE_BOTH, 1'b0, 1'b1, 1'b1},
    '{gpi_pkg::EDGE_BOTH, 1'b1, 1'b0, 1'b1}};

  always #5 sys_clk = ~sys_clk;

  gpi_port #(.PINS(8), .PORT_VECTOR(VEC)) gpi_port_inst (.sys_clk(sys_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .thresh_lvttl(thresh_lvttl),
    .port_irq(port_irq), .port_irq_vector(port_irq_vector), .irq(irq));
  gpi_pin_model #(.PINS(8)) gpi_pin_model_inst (.sys_clk(sys_clk), .ext_en(ext_en),
    .ext_val(ext_val), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .port_irq(port_irq), .pin_in(pin_in), .n_irq(n_irq));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic test_done;
    $display("counts: %0d compares, %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge sys_clk);
      k++;
      if (k > 50) begin
        n_fail++;
        test_done();
      end
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic pins(input logic [7:0] v);
    @(posedge sys_clk);
    ext_val <= v;
    repeat (8) @(negedge sys_clk);
  endtask : pins

  task automatic clr;
    bus(1'b1, gpi_pkg::REG_PIN_CLEAR, 32'h0000_00FF);
    bus(1'b1, gpi_pkg::REG_IRQ_CLEAR, 32'h0000_0003);
    repeat (2) @(negedge sys_clk);
  endtask : clr

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    #200_000;
    n_fail++;
    test_done();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk({28'h000_0000, irq, port_irq, avs_waitrequest, thresh_lvttl}, 32'h0000_0002, "rst");
    for (int a = 0; a < 10; a++) begin
      bus(1'b0, 8'(a * 4), 32'h0000_0000);
      chk(rd, gpi_pkg::RESET_VALUE, "reset value");
    end
    bus(1'b0, 8'h30, 32'h0000_0000);
    chk(rd, gpi_pkg::UNMAPPED_READ, "unmapped read");
    $display("done: reset and map");
    foreach (rows[i]) begin
      bus(1'b1, gpi_pkg::REG_EDGE_MODE, 32'h0000_0000);
      pins({7'h00, rows[i].v0});
      clr();
      bus(1'b1, gpi_pkg::REG_EDGE_MODE, {30'h0, rows[i].mode});
      pins({7'h00, rows[i].v1});
      bus(1'b0, gpi_pkg::REG_PIN_STATUS, 32'h0000_0000);
      chk(rd, {31'h0, rows[i].hit}, "edge mode row");
    end
    $display("done: edge mode table");
    bus(1'b1, gpi_pkg::REG_EDGE_MODE, 32'h0000_0840);
    pins(8'h20);
    clr();
    pins(8'h00);
    chk({23'h00_0000, port_irq, port_irq_vector}, {24'h00_0001, VEC}, "level req");
    repeat (20) @(negedge sys_clk);
    chk({31'h0, port_irq}, 32'h0000_0001, "level holds");
    clr();
    chk({31'h0, port_irq}, 32'h0000_0000, "level cleared");
    bus(1'b1, gpi_pkg::REG_IRQ_ENABLE, 32'h0000_0001);
    pins(8'h08);
    chk({31'h0, port_irq}, 32'h0000_0001, "other pin req");
    bus(1'b0, gpi_pkg::REG_IRQ_STATUS, 32'h0000_0000);
    chk({31'h0, rd[gpi_pkg::EVT_PIN]}, 32'h0000_0001, "irq status");
    chk({31'h0, irq}, 32'h0000_0001, "irq raised");
    bus(1'b1, gpi_pkg::REG_IRQ_ENABLE, 32'h0000_0000);
    repeat (2) @(negedge sys_clk);
    chk({31'h0, irq}, 32'h0000_0000, "irq masked");
    bus(1'b1, gpi_pkg::REG_IRQ_ENABLE, 32'h0000_0001);
    bus(1'b1, gpi_pkg::REG_IRQ_CLEAR, 32'h0000_0001);
    repeat (2) @(negedge sys_clk);
    chk({31'h0, irq}, 32'h0000_0000, "irq cleared");
    $display("done: level route and interrupt");
    bus(1'b1, gpi_pkg::REG_PORT_CFG, 32'h0000_3302);
    pins(8'h00);
    clr();
    base = n_irq;
    pins(8'h08);
    chk(n_irq - base, 32'h0000_0001, "edge pulse");
    chk({24'h00_0000, port_irq_vector}, 32'h0000_0033, "edge vector");
    pins(8'h00);
    pins(8'h08);
    chk(n_irq - base, 32'h0000_0001, "no refire");
    clr();
    pins(8'h00);
    pins(8'h08);
    chk(n_irq - base, 32'h0000_0002, "rearmed");
    $display("done: edge route");
    bus(1'b1, gpi_pkg::REG_PORT_CFG, 32'h0000_0001);
    repeat (2) @(negedge sys_clk);
    chk({31'h0, thresh_lvttl}, 32'h0000_0001, "lvttl");
    bus(1'b1, gpi_pkg::REG_PORT_CFG, 32'h0000_0000);
    repeat (2) @(negedge sys_clk);
    chk({31'h0, thresh_lvttl}, 32'h0000_0000, "cmos");
    @(posedge sys_clk);
    ext_en <= 8'h00;
    bus(1'b1, gpi_pkg::REG_OUT_DATA, 32'h0000_000F);
    bus(1'b1, gpi_pkg::REG_DRIVE_MODE, 32'h0000_FFFF);
    repeat (2) @(negedge sys_clk);
    chk({16'h0000, pull_up_en, pull_down_en}, 32'h0000_00F0, "pull down");
    repeat (6) @(negedge sys_clk);
    bus(1'b0, gpi_pkg::REG_PIN_IN, 32'h0000_0000);
    chk(rd & 32'h0000_00F0, 32'h0000_0000, "pulled low");
    bus(1'b1, gpi_pkg::REG_DRIVE_MODE, 32'h0000_AAAA);
    repeat (2) @(negedge sys_clk);
    chk({16'h0000, pull_up_en, pull_down_en}, 32'h0000_0F00, "pull up");
    repeat (6) @(negedge sys_clk);
    bus(1'b0, gpi_pkg::REG_PIN_IN, 32'h0000_0000);
    chk(rd & 32'h0000_000F, 32'h0000_000F, "pulled high");
    bus(1'b1, gpi_pkg::REG_DRIVE_MODE, 32'h0000_5555);
    repeat (2) @(negedge sys_clk);
    chk({16'h0000, pin_oe, pin_out}, 32'h0000_FF0F, "strong");
    $display("done: threshold and drive");
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk({16'h0000, pin_oe, pull_up_en}, 32'h0000_0000, "mid reset pads");
    chk({28'h000_0000, irq, port_irq, avs_waitrequest, thresh_lvttl}, 32'h0000_0002, "mid rst");
    bus(1'b0, gpi_pkg::REG_DRIVE_MODE, 32'h0000_0000);
    chk(rd, gpi_pkg::RESET_VALUE, "mid reset regs");
    $display("done: mid-run reset");
    test_done();
  end
endmodule : gpi_port_test
`default_nettype wire
